// ---- pkg/bpf_pkg.sv ----
// bpf_pkg: shared constants and types for the bus port pin function select
// assumes one 20 MHz clock domain and an 8-bit register port
package bpf_pkg;

   // register port widths
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [9:0] PMC0_OFS = 10'h004;
   localparam logic [9:0] P1DIR_OFS = 10'h3E3;
   localparam logic [9:0] P2DIR_OFS = 10'h3E6;
   localparam logic [9:0] PUC_OFS = 10'h3FC;
   localparam logic [9:0] FNSTAT_OFS = 10'h3F0;

   // reset values: single-chip mode, all pins input, no pull-ups
   localparam logic [7:0] PMC0_RST = 8'h00;
   localparam logic [7:0] P1DIR_RST = 8'h00;
   localparam logic [7:0] P2DIR_RST = 8'h00;
   localparam logic [7:0] PUC_RST = 8'h00;

   // field positions
   localparam int PM_B0 = 0;
   localparam int PM_B1 = 1;
   localparam int MBS_B0 = 4;
   localparam int MBS_B1 = 5;
   localparam int DIR_LOW_ADDR = 0;
   localparam int DIR_P1_SIX = 6;
   localparam int DIR_P1_SEVEN = 7;
   localparam int PU_LOW_ADDR = 4;
   localparam int PU_UPPER = 3;
   localparam int FNSTAT_NARROW = 4;

   // pin lanes handled by this block
   localparam int LANE_LOW_ADDR = 0;
   localparam int LANE_P1_SIX = 1;
   localparam int LANE_P1_SEVEN = 2;
   localparam int NUM_LANES = 3;

   // function chosen for one pin, one-hot
   typedef enum logic [7:0] {
      FN_PORT_IN = 8'h01,
      FN_PORT_IN_PU = 8'h02,
      FN_PORT_OUT = 8'h04,
      FN_ADDR_OUT = 8'h08,
      FN_MUX_AD = 8'h10,
      FN_MUX_A_ONLY = 8'h20,
      FN_DATA_BUS = 8'h40,
      FN_RELEASED = 8'h80
   } bpf_fn_t;

   typedef bpf_fn_t [NUM_LANES-1:0] bpf_fn_vec_t;

   // drive of one pin: level, output enable, pull-up enable
   typedef struct packed {
      logic out;
      logic oe;
      logic pu;
   } bpf_pin_drv_t;

   // request from the external bus controller
   typedef struct packed {
      logic addr_phase;
      logic addr0;
      logic data_oe;
      logic data_line_zero;
      logic data_line_fourteen;
      logic data_line_fifteen;
   } bpf_bus_req_t;

endpackage : bpf_pkg

// ---- design/bpf_fn_decode.sv ----
// bpf_fn_decode: picks the function of each pin from the control registers
// assumes register values are stable flops of the top module
`timescale 1ns/1ps
module bpf_fn_decode (
   input wire logic [7:0] i_pmc0,
   input wire logic [7:0] i_p1dir,
   input wire logic [7:0] i_p2dir,
   input wire logic [7:0] i_puc,
   input wire logic i_narrow_bus_pin,
   output bpf_pkg::bpf_fn_vec_t o_fn
);
   import bpf_pkg::*;

   // port function from direction and pull-up bits
   function automatic bpf_fn_t port_fn(input logic dir, input logic pu);
      if (dir) begin
         return FN_PORT_OUT; // R01
      end
      return pu ? FN_PORT_IN_PU : FN_PORT_IN; // R01 R02
   endfunction : port_fn

   // function of one pin from mode, bus select, width pin and port bits
   function automatic bpf_fn_t lane_fn(input logic is_low_addr,
         input logic pm0, input logic [1:0] mbs, input logic narrow,
         input logic dir, input logic pu);
      if (!pm0) begin
         return port_fn(dir, pu); // R01
      end
      if (is_low_addr) begin
         if (mbs == 2'b00) begin
            return FN_ADDR_OUT; // R03
         end
         return narrow ? FN_MUX_AD : FN_MUX_A_ONLY; // R03
      end
      if (narrow) begin
         return port_fn(dir, pu); // R04
      end
      return (mbs != 2'b11) ? FN_DATA_BUS : FN_RELEASED; // R05
   endfunction : lane_fn

   logic pm0;
   logic [1:0] mbs;

   // one decode per lane
   assign pm0 = i_pmc0[PM_B0];
   assign mbs = {i_pmc0[MBS_B1], i_pmc0[MBS_B0]};
   assign o_fn[LANE_LOW_ADDR] = lane_fn(1'b1, pm0, mbs, i_narrow_bus_pin,
      i_p2dir[DIR_LOW_ADDR], i_puc[PU_LOW_ADDR]);
   assign o_fn[LANE_P1_SIX] = lane_fn(1'b0, pm0, mbs, i_narrow_bus_pin,
      i_p1dir[DIR_P1_SIX], i_puc[PU_UPPER]);
   assign o_fn[LANE_P1_SEVEN] = lane_fn(1'b0, pm0, mbs, i_narrow_bus_pin,
      i_p1dir[DIR_P1_SEVEN], i_puc[PU_UPPER]);

endmodule : bpf_fn_decode

// ---- design/bpf_pin_select.sv ----
// bpf_pin_select: function select for the lowest address pin and two
// upper data pins, with its control registers on a plain register port
// assumes synchronous pin inputs and a bus controller giving bus drive
// Functional notes
// (R01) single-chip, direction 0: input, unpulled if pull-up bit 0; 1: output
// (R02) input port pin with pull-up bit 1 gets internal pull-up
// (R03) bus mode: select 00 gives address out, else multiplexed address/data; with width pin low the pin carries the address only
// (R04) upper pins keep port and interrupt use in bus mode if width pin high
// (R05) bus mode, width pin low, select not 11: upper pins are data lines
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module bpf_pin_select (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [9:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_narrow_bus_pin,
   input wire bpf_pkg::bpf_bus_req_t i_bus,
   input wire logic [2:0] i_port_latch,
   input wire logic [2:0] i_pin,
   output bpf_pkg::bpf_pin_drv_t [2:0] o_pin_drv,
   output logic [2:0] o_port_in,
   output logic [2:0] o_bus_din,
   output logic [1:0] o_irq_n
);
   import bpf_pkg::*;

   logic [7:0] pmc0_r, pmc0_nxt;
   logic [7:0] p1dir_r, p1dir_nxt;
   logic [7:0] p2dir_r, p2dir_nxt;
   logic [7:0] puc_r, puc_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   bpf_pin_drv_t [2:0] drv_r, drv_nxt;
   logic [2:0] port_in_r, port_in_nxt;
   logic [2:0] bus_din_r, bus_din_nxt;
   logic [1:0] irq_n_r, irq_n_nxt;
   bpf_fn_vec_t fn;
   logic [2:0] bus_act;
   logic [2:0] dbit;

   // pin function decode from the control registers
   bpf_fn_decode u_decode (
      .i_pmc0(pmc0_r),
      .i_p1dir(p1dir_r),
      .i_p2dir(p2dir_r),
      .i_puc(puc_r),
      .i_narrow_bus_pin(i_narrow_bus_pin),
      .o_fn(fn)
   );

   // lanes currently owned by the external bus
   always_comb begin
      for (int k = 0; k < NUM_LANES; k++) begin
         bus_act[k] = !(fn[k] inside {FN_PORT_IN, FN_PORT_IN_PU, FN_PORT_OUT});
      end
   end

   // data bit carried by each lane in the data phase
   assign dbit = {i_bus.data_line_fifteen, i_bus.data_line_fourteen,
      i_bus.data_line_zero};

   // register writes and read data
   always_comb begin
      pmc0_nxt = pmc0_r;
      p1dir_nxt = p1dir_r;
      p2dir_nxt = p2dir_r;
      puc_nxt = puc_r;
      rdata_nxt = 8'h00;
      if (i_wr) begin
         unique case (i_addr)
            PMC0_OFS: pmc0_nxt = i_wdata;
            P1DIR_OFS: p1dir_nxt = i_wdata;
            P2DIR_OFS: p2dir_nxt = i_wdata;
            PUC_OFS: puc_nxt = i_wdata;
            default: ; // unmapped write ignored
         endcase
      end
      if (i_rd) begin
         unique case (i_addr)
            PMC0_OFS: rdata_nxt = pmc0_r;
            P1DIR_OFS: rdata_nxt = p1dir_r;
            P2DIR_OFS: rdata_nxt = p2dir_r;
            PUC_OFS: rdata_nxt = puc_r;
            FNSTAT_OFS: rdata_nxt = {3'b000, i_narrow_bus_pin, 1'b0, bus_act};
            default: rdata_nxt = 8'h00; // unmapped read gives zero
         endcase
      end
   end

   // register file flops
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pmc0_r <= PMC0_RST;
         p1dir_r <= P1DIR_RST;
         p2dir_r <= P2DIR_RST;
         puc_r <= PUC_RST;
         rdata_r <= 8'h00;
      end else begin
         pmc0_r <= pmc0_nxt;
         p1dir_r <= p1dir_nxt;
         p2dir_r <= p2dir_nxt;
         puc_r <= puc_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // pin drive per lane from its function
   always_comb begin
      drv_nxt = '0;
      for (int k = 0; k < NUM_LANES; k++) begin
         unique case (fn[k])
            FN_PORT_IN: drv_nxt[k] = '0; // R01
            FN_PORT_IN_PU: drv_nxt[k].pu = 1'b1; // R02
            FN_PORT_OUT: begin
               drv_nxt[k].out = i_port_latch[k]; // R01
               drv_nxt[k].oe = 1'b1; // R01
            end
            FN_ADDR_OUT: begin
               drv_nxt[k].out = i_bus.addr0; // R03
               drv_nxt[k].oe = 1'b1; // R03
            end
            FN_MUX_AD: begin
               // address phase drives the address, data phase the data
               drv_nxt[k].out = i_bus.addr_phase ? i_bus.addr0 :
                  dbit[k]; // R03
               drv_nxt[k].oe = i_bus.addr_phase | i_bus.data_oe; // R03
            end
            FN_MUX_A_ONLY: begin
               // 16-bit bus: no data bit on this pin
               drv_nxt[k].out = i_bus.addr0; // R03
               drv_nxt[k].oe = i_bus.addr_phase; // R03
            end
            FN_DATA_BUS: begin
               drv_nxt[k].out = dbit[k]; // R05
               drv_nxt[k].oe = i_bus.data_oe & !i_bus.addr_phase; // R05
            end
            FN_RELEASED: drv_nxt[k] = '0;
         endcase
      end
   end

   // pin levels to port, bus and interrupt inputs
   always_comb begin
      port_in_nxt = i_pin;
      bus_din_nxt = i_pin;
      for (int j = 0; j < 2; j++) begin
         // interrupt input only while the pin is a port input
         irq_n_nxt[j] = (fn[j+1] inside {FN_PORT_IN, FN_PORT_IN_PU}) ?
            i_pin[j+1] : 1'b1; // R04
      end
   end

   // output flops
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         drv_r <= '0;
         port_in_r <= 3'h0;
         bus_din_r <= 3'h0;
         irq_n_r <= 2'h3;
      end else begin
         drv_r <= drv_nxt;
         port_in_r <= port_in_nxt;
         bus_din_r <= bus_din_nxt;
         irq_n_r <= irq_n_nxt;
      end
   end

   assign o_rdata = rdata_r;
   assign o_pin_drv = drv_r;
   assign o_port_in = port_in_r;
   assign o_bus_din = bus_din_r;
   assign o_irq_n = irq_n_r;

   // checks on the selected pin functions
   logic single_chip;
   logic bus_mode;
   assign single_chip = pmc0_r[PM_B0] == 1'b0 && pmc0_r[PM_B1] == 1'b0;
   assign bus_mode = pmc0_r[PM_B0];

   sequence s_data_phase;
      !i_bus.addr_phase && i_bus.data_oe;
   endsequence

   sequence s_narrow_mux;
      bus_mode && i_narrow_bus_pin &&
         {pmc0_r[MBS_B1], pmc0_r[MBS_B0]} != 2'b00;
   endsequence

   port_input_a: assert property (@(posedge i_clk) // R01
      disable iff (!i_rst_n)
      single_chip && !p2dir_r[DIR_LOW_ADDR] && !puc_r[PU_LOW_ADDR]
      |=> !o_pin_drv[LANE_LOW_ADDR].oe && !o_pin_drv[LANE_LOW_ADDR].pu)
      else $error("port input pin driven or pulled up");

   port_output_a: assert property (@(posedge i_clk) // R01
      disable iff (!i_rst_n)
      single_chip && p1dir_r[DIR_P1_SEVEN]
      |=> o_pin_drv[LANE_P1_SEVEN].oe &&
         o_pin_drv[LANE_P1_SEVEN].out == $past(i_port_latch[LANE_P1_SEVEN]))
      else $error("port output pin not driving latch value");

   pullup_enable_a: assert property (@(posedge i_clk) // R02
      disable iff (!i_rst_n)
      single_chip && !p1dir_r[DIR_P1_SIX] && puc_r[PU_UPPER]
      |=> o_pin_drv[LANE_P1_SIX].pu && !o_pin_drv[LANE_P1_SIX].oe)
      else $error("pull-up missing on input pin");

   addr_output_a: assert property (@(posedge i_clk) // R03
      disable iff (!i_rst_n)
      bus_mode && {pmc0_r[MBS_B1], pmc0_r[MBS_B0]} == 2'b00
      |=> o_pin_drv[LANE_LOW_ADDR].oe &&
         o_pin_drv[LANE_LOW_ADDR].out == $past(i_bus.addr0))
      else $error("address pin not driving address");

   mux_data_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R03
      s_narrow_mux ##0 s_data_phase
      |=> o_pin_drv[LANE_LOW_ADDR].oe &&
         o_pin_drv[LANE_LOW_ADDR].out == $past(i_bus.data_line_zero))
      else $error("multiplexed pin missing data bit zero");

   mux_wide_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R03
      bus_mode && !i_narrow_bus_pin && !i_bus.addr_phase &&
         {pmc0_r[MBS_B1], pmc0_r[MBS_B0]} != 2'b00
      |=> !o_pin_drv[LANE_LOW_ADDR].oe)
      else $error("wide-bus multiplexed pin drives in data phase");

   irq_route_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R04
      bus_mode && i_narrow_bus_pin && !p1dir_r[DIR_P1_SIX]
      |=> o_irq_n[0] == $past(i_pin[LANE_P1_SIX]) &&
         !o_pin_drv[LANE_P1_SIX].oe)
      else $error("interrupt input not routed in narrow bus mode");

   data_bus_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R05
      bus_mode && !i_narrow_bus_pin &&
         {pmc0_r[MBS_B1], pmc0_r[MBS_B0]} != 2'b11 ##0 s_data_phase
      |=> o_pin_drv[LANE_P1_SEVEN].oe &&
         o_pin_drv[LANE_P1_SEVEN].out == $past(i_bus.data_line_fifteen) &&
         o_irq_n[1])
      else $error("upper pin not acting as data line");

   read_data_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_rd && i_addr == PUC_OFS |=> o_rdata == $past(puc_r))
      else $error("read data does not match register");

endmodule : bpf_pin_select

// ---- verification/bpf_pin_model.sv ----
// bpf_pin_model: far side of the three pins, an external bus device
// assumes the pin drive struct of bpf_pkg and the block's single clock
`timescale 1ns/1ps
module bpf_pin_model (
   input wire logic i_clk,
   input wire bpf_pkg::bpf_pin_drv_t [2:0] i_drv,
   input wire logic [2:0] i_ext_oe,
   input wire logic [2:0] i_ext_val,
   output logic [2:0] o_pin
);
   import bpf_pkg::*;
   logic [2:0] float_r = 3'h5;

   // a floating pin wanders every cycle, so a stale value never matches
   always_ff @(posedge i_clk) begin
      float_r <= ~float_r;
   end

   // wire level: block drive, then external drive, then pull-up
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         if (i_drv[k].oe) begin
            o_pin[k] = i_drv[k].out;
         end else if (i_ext_oe[k]) begin
            o_pin[k] = i_ext_val[k];
         end else if (i_drv[k].pu) begin
            o_pin[k] = 1'b1;
         end else begin
            o_pin[k] = float_r[k];
         end
      end
   end
endmodule : bpf_pin_model

// ---- verification/tb_bpf_pin_select.sv ----
// tb_bpf_pin_select: register and pin function checks of bpf_pin_select
// assumes bpf_pkg compiled first and the pin model on the far side
`timescale 1ns/1ps
module tb_bpf_pin_select;
   import bpf_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic narrow = 1'b1;
   logic [9:0] i_addr = 10'h000;
   logic [7:0] i_wdata = 8'h00;
   logic [7:0] o_rdata;
   bpf_bus_req_t bus = 6'h00;
   logic [2:0] latch = 3'h0;
   logic [2:0] pin, port_in, bus_din;
   logic [2:0] ext_oe = 3'h0;
   logic [2:0] ext_val = 3'h0;
   bpf_pin_drv_t [2:0] drv;
   logic [1:0] irq_n;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;

   // 20 MHz clock
   always #25 i_clk = ~i_clk;

   bpf_pin_select u_dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_narrow_bus_pin(narrow), .i_bus(bus), .i_port_latch(latch),
      .i_pin(pin), .o_pin_drv(drv), .o_port_in(port_in),
      .o_bus_din(bus_din), .o_irq_n(irq_n)
   );

   bpf_pin_model u_far (
      .i_clk(i_clk), .i_drv(drv), .i_ext_oe(ext_oe),
      .i_ext_val(ext_val), .o_pin(pin)
   );

   // verdict and end of run
   task test_done;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one-cycle write strobe
   task wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   // one-cycle read strobe, data looked at in the following cycle only
   task rd(input logic [9:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask : rd

   task settle;
      repeat (3) @(posedge i_clk);
      #1;
   endtask : settle

   // lane drive as {out, oe, pu}
   function automatic logic [7:0] f(input int k);
      return {5'h00, drv[k]};
   endfunction : f

   // hang guard
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         test_done();
      end
   end

   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd(PMC0_OFS, 8'h00);
      rd(P1DIR_OFS, 8'h00);
      rd(P2DIR_OFS, 8'h00);
      rd(PUC_OFS, 8'h00);
      wr(10'h100, 8'hFF);
      rd(10'h100, 8'h00);
      wr(P1DIR_OFS, 8'hC0);
      rd(P1DIR_OFS, 8'hC0);
      // single-chip port input, then port output from the latch
      wr(P2DIR_OFS, 8'h00);
      settle;
      chk(f(0) & 8'h03, 8'h00);
      @(posedge i_clk);
      latch <= 3'h1;
      wr(P2DIR_OFS, 8'h01);
      settle;
      chk(f(0), 8'h06);
      @(posedge i_clk);
      latch <= 3'h0;
      settle;
      chk(f(0), 8'h02);
      // pull-ups per group bit, upper pins as inputs with interrupts
      wr(P2DIR_OFS, 8'h00);
      wr(P1DIR_OFS, 8'h00);
      wr(PUC_OFS, 8'h18);
      ext_oe <= 3'h6;
      ext_val <= 3'h2;
      settle;
      chk(f(0) & 8'h03, 8'h01);
      chk(f(1) & 8'h03, 8'h01);
      chk(f(2) & 8'h03, 8'h01);
      chk({6'h00, irq_n}, 8'h01);
      chk({5'h00, port_in} & 8'h06, 8'h02);
      rd(FNSTAT_OFS, 8'h10);
      wr(PUC_OFS, 8'h10);
      settle;
      chk(f(1) & 8'h03, 8'h00);
      // bus mode, 8-bit width: address out, upper pins stay ports
      @(posedge i_clk);
      bus <= 6'h30;
      wr(PMC0_OFS, 8'h01);
      settle;
      chk(f(0) & 8'h06, 8'h06);
      chk({6'h00, irq_n}, 8'h01);
      chk(f(1) & 8'h03, 8'h00);
      // multiplexed lane carries data bit 0 in the data phase
      @(posedge i_clk);
      bus <= 6'h18;
      wr(PMC0_OFS, 8'h11);
      settle;
      chk(f(0) & 8'h06, 8'h02);
      // 16-bit width: upper pins become data lines
      @(posedge i_clk);
      ext_oe <= 3'h0;
      narrow <= 1'b0;
      bus <= 6'h1A;
      settle;
      chk(f(0) & 8'h02, 8'h00);
      chk(f(1) & 8'h06, 8'h06);
      chk(f(2) & 8'h06, 8'h02);
      chk({6'h00, irq_n}, 8'h03);
      chk({5'h00, bus_din} & 8'h06, 8'h02);
      rd(FNSTAT_OFS, 8'h07);
      @(posedge i_clk);
      bus <= 6'h30;
      settle;
      chk(f(1) & 8'h02, 8'h00);
      // select 11 releases the upper pins
      wr(PMC0_OFS, 8'h31);
      settle;
      chk(f(1) & 8'h03, 8'h00);
      chk(f(0) & 8'h06, 8'h06);
      // reset in mid-run restores single-chip mode
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd(PMC0_OFS, 8'h00);
      test_done();
   end
endmodule : tb_bpf_pin_select
